// ### ssr_pkg.sv
package ssr_pkg;

	////////////////////////////////////////////////////////////////////////
	// word and frame shape
	localparam int SSR_W         = 16;
	localparam int SSR_CNT_W     = 4;

	////////////////////////////////////////////////////////////////////////
	// command word fields
	localparam int SSR_ADDR_HI   = 15;
	localparam int SSR_ADDR_LO   = 13;
	localparam int SSR_SEL_HI    = 11;
	localparam int SSR_SEL_LO    = 8;
	localparam int SSR_EN1_BIT   = 1;
	localparam int SSR_EN0_BIT   = 0;
	localparam logic [2:0] SSR_ENCFG_ADDR = 3'h0;
	localparam logic [3:0] SSR_SEL_RESET  = 4'h0;

	////////////////////////////////////////////////////////////////////////
	// device status word bit positions
	localparam int SSR_B_HEAD1   = 15;
	localparam int SSR_B_HEAD0   = 14;
	localparam int SSR_B_HOME1   = 13;
	localparam int SSR_B_HOME0   = 12;
	localparam int SSR_B_PEND1   = 11;
	localparam int SSR_B_PEND0   = 10;
	localparam int SSR_B_HIGH    = 9;
	localparam int SSR_B_LOW     = 8;
	localparam int SSR_B_CAL     = 7;
	localparam int SSR_B_FAULT   = 6;
	localparam int SSR_B_GAUGE1_SHIFTED_FLAG    = 5;
	localparam int SSR_B_GAUGE0_SHIFTED_FLAG    = 4;
	localparam int SSR_B_GAUGE1_HOMING    = 3;
	localparam int SSR_B_GAUGE0_HOMING    = 2;
	localparam int SSR_B_HEAT1   = 1;
	localparam int SSR_B_HEAT0   = 0;

	// sticky bits cleared by a valid read of the device status word
	localparam logic [15:0] SSR_READ_CLR_MASK = 16'h0370;
	localparam logic [15:0] SSR_STICKY_RESET  = 16'h0000;
	localparam logic [15:0] SSR_WORD_RESET    = 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// frame state
	typedef enum logic [0:0]
	{
		SSR_IDLE  = 1'b0,
		SSR_SHIFT = 1'b1
	} ssr_state_t;

endpackage

// ### ssr_top.sv
`timescale 1ns/1ns
// Operation
// - on select fall, load chosen status word; shift it out msb first
// - on select rise, accept only nonzero multiple-of-16 bit frames
// - after select rise, output floats and status may update again
// - fault flags held until device status word read in valid frame
// - invalid frame length leaves every latched fault flag set
// - pointer fields show live pointer state
// - after sixteen bits, output echoes bits taken in since select fell
// - five word types; selector kept until rewritten or reset
// - selector msb zero picks device status word, other bits ignored
// - 10xx accumulator, 1100 gauge0, 1101 gauge1, 111x velocity
// - bits 15,14 give gauge1, gauge0 heading
// - bits 13,12 give gauge1, gauge0 home side
// - bits 11,10 one while gauge not at commanded position
// - bit 9 flags overvoltage; coil drivers disabled on overvoltage
// - bit 8 flags undervoltage only, drivers stay on
// - bit 7 follows clock calibration out of tolerance
// - bit 6 set on either supply event
// - bits 5,4 set when gauge position changed since last device status read
// - bits 3,2 set while homing, until frame after zero found
// - bits 1,0 heat trip disables gauge, held until re-enabled
// - status bits are read only; written data alters only bits 1,0, cleared by re-enable
module ssr_top
(
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     spi_sclk,
	input  wire logic                     spi_cs_n,
	input  wire logic                     spi_si,
	output logic                          spi_so,
	output logic                          spi_so_oe,
	input  wire logic                     gauge1_heading,
	input  wire logic                     gauge0_heading,
	input  wire logic                     gauge1_home_side,
	input  wire logic                     gauge0_home_side,
	input  wire logic                     gauge1_pending,
	input  wire logic                     gauge0_pending,
	input  wire logic                     supply_high_event,
	input  wire logic                     supply_low_event,
	input  wire logic                     clock_cal_bad,
	input  wire logic                     gauge1_moved,
	input  wire logic                     gauge0_moved,
	input  wire logic                     gauge1_homing_active,
	input  wire logic                     gauge0_homing_active,
	input  wire logic                     gauge1_homing_cancel,
	input  wire logic                     gauge0_homing_cancel,
	input  wire logic                     gauge1_heat_event,
	input  wire logic                     gauge0_heat_event,
	input  wire logic [ssr_pkg::SSR_W-1:0] homing_acc_word,
	input  wire logic [ssr_pkg::SSR_W-1:0] gauge0_pos_word,
	input  wire logic [ssr_pkg::SSR_W-1:0] gauge1_pos_word,
	input  wire logic [ssr_pkg::SSR_W-1:0] velocity_word,
	output logic [ssr_pkg::SSR_W-1:0]      cmd_word,
	output logic                          cmd_valid,
	output logic [3:0]                    status_selector,
	output logic                          gauge1_drive_off,
	output logic                          gauge0_drive_off,
	output logic                          gauge1_reenable,
	output logic                          gauge0_reenable
);
	import ssr_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [2:0]           sclk_q;
	logic [2:0]           cs_q;
	logic [1:0]           si_q;
	ssr_state_t           state;
	ssr_state_t           next_state;
	logic [SSR_W-1:0]     sr;
	logic [SSR_CNT_W-1:0] bit_cnt;
	logic                 has_bits;
	logic [SSR_W-1:0]     snap;
	logic                 dev_frame;
	logic [SSR_W-1:0]     sticky;
	logic [SSR_W-1:0]     next_sticky;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclk_q <= 3'h0;
			cs_q   <= 3'h7;
			si_q   <= 2'h0;
		end
		else
		begin
			sclk_q <= {sclk_q[1:0], spi_sclk};
			cs_q   <= {cs_q[1:0], spi_cs_n};
			si_q   <= {si_q[0], spi_si};
		end
	end

	wire sclk_rise = sclk_q[1] & ~sclk_q[2];
	wire cs_fall   = cs_q[2] & ~cs_q[1];
	wire cs_rise   = ~cs_q[2] & cs_q[1];
	wire in_frame  = (state == SSR_SHIFT);
	wire frame_end = cs_rise & in_frame;
	wire valid_len = has_bits & (bit_cnt == '0);
	wire frame_ok  = frame_end & valid_len;
	wire is_encfg  = frame_ok & (sr[SSR_ADDR_HI:SSR_ADDR_LO] == SSR_ENCFG_ADDR);
	wire clr_ok    = frame_ok & dev_frame;

	////////////////////////////////////////////////////////////////////////
	// status word assembly
	wire [SSR_W-1:0] live_word;
	wire [SSR_W-1:0] dev_word;
	wire [SSR_W-1:0] sel_word;
	wire [SSR_W-1:0] set_vec;
	wire [SSR_W-1:0] clr_vec;
	wire             reen1;
	wire             reen0;

	assign live_word = {gauge1_heading, gauge0_heading,
		gauge1_home_side, gauge0_home_side,
		gauge1_pending, gauge0_pending,
		2'b00, clock_cal_bad,
		7'h00};
	assign dev_word = live_word | sticky;

	assign sel_word = !status_selector[3] ? dev_word :
		!status_selector[2] ? homing_acc_word :
		status_selector[1] ? velocity_word :
		status_selector[0] ? gauge1_pos_word : gauge0_pos_word;

	assign reen1 = is_encfg & sr[SSR_EN1_BIT];
	assign reen0 = is_encfg & sr[SSR_EN0_BIT];

	// events that set latched flags
	assign set_vec = {6'h00,
		supply_high_event,
		supply_low_event,
		1'b0,
		supply_high_event | supply_low_event,
		gauge1_moved, gauge0_moved,
		gauge1_homing_active, gauge0_homing_active,
		gauge1_heat_event, gauge0_heat_event};

	// read clears act only on the reported snapshot bits; cancel and re-enable clear directly
	assign clr_vec = ({SSR_W{clr_ok}} & snap & SSR_READ_CLR_MASK)
		| {12'h000,
		(clr_ok & snap[SSR_B_GAUGE1_HOMING] & ~gauge1_homing_active)
			| gauge1_homing_cancel,
		(clr_ok & snap[SSR_B_GAUGE0_HOMING] & ~gauge0_homing_active)
			| gauge0_homing_cancel,
		reen1, reen0};

	////////////////////////////////////////////////////////////////////////
	// latched flags; set wins over clear
	genvar gi;
	generate
		for (gi = 0; gi < SSR_W; gi++)
		begin : g_flag
			assign next_sticky[gi] = set_vec[gi]
				| (sticky[gi] & ~clr_vec[gi]);
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			sticky <= SSR_STICKY_RESET;
		else
			sticky <= next_sticky;
	end

	////////////////////////////////////////////////////////////////////////
	// frame state
	always_comb
	begin
		next_state = state;
		case (state)
			SSR_IDLE:  if (cs_fall) next_state = SSR_SHIFT;
			SSR_SHIFT: if (cs_rise) next_state = SSR_IDLE;
			default:   next_state = SSR_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state <= SSR_IDLE;
		else
			state <= next_state;
	end

	////////////////////////////////////////////////////////////////////////
	// shift register: status out first, then the echoed input bits
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sr       <= SSR_WORD_RESET;
			bit_cnt  <= '0;
			has_bits <= 1'b0;
		end
		else if (cs_fall)
		begin
			sr       <= sel_word;
			bit_cnt  <= '0;
			has_bits <= 1'b0;
		end
		else if (in_frame && sclk_rise)
		begin
			sr       <= {sr[SSR_W-2:0], si_q[1]};
			bit_cnt  <= bit_cnt + 1'b1;
			has_bits <= 1'b1;
		end
	end

	// snapshot held for the coherent clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			snap      <= SSR_WORD_RESET;
			dev_frame <= 1'b0;
		end
		else if (cs_fall)
		begin
			snap      <= dev_word;
			dev_frame <= ~status_selector[3];
		end
	end

	assign spi_so    = sr[SSR_W-1];
	assign spi_so_oe = in_frame;

	////////////////////////////////////////////////////////////////////////
	// command latch; status bits are not written, except that re-enable clears bits 1,0
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_word        <= SSR_WORD_RESET;
			cmd_valid       <= 1'b0;
			status_selector <= SSR_SEL_RESET;
			gauge1_reenable <= 1'b0;
			gauge0_reenable <= 1'b0;
		end
		else
		begin
			cmd_valid       <= frame_ok;
			gauge1_reenable <= reen1;
			gauge0_reenable <= reen0;
			if (frame_ok)
				cmd_word <= sr;
			if (is_encfg)
				status_selector <= sr[SSR_SEL_HI:SSR_SEL_LO];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// coil driver disable
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gauge1_drive_off <= 1'b0;
			gauge0_drive_off <= 1'b0;
		end
		else
		begin
			gauge1_drive_off <= supply_high_event | gauge1_heat_event
				| (gauge1_drive_off & ~reen1);
			gauge0_drive_off <= supply_high_event | gauge0_heat_event
				| (gauge0_drive_off & ~reen0);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_frame_end;
		cs_rise && in_frame;
	endsequence

	sequence s_bad_end;
		s_frame_end ##0 !(has_bits && bit_cnt == '0);
	endsequence

	property p_load;
		cs_fall |=> sr == $past(sel_word) && spi_so_oe;
	endproperty
	a_load: assert property (p_load)
		else $error("status word not loaded at select fall");

	property p_len;
		s_bad_end |=> !cmd_valid && $stable(status_selector);
	endproperty
	a_len: assert property (p_len)
		else $error("bad length frame accepted");

	property p_float;
		s_frame_end |=> !spi_so_oe ##1 !spi_so_oe || cs_fall;
	endproperty
	a_float: assert property (p_float)
		else $error("output driven after select rise");

	property p_keep;
		s_bad_end |=>
			(($past(sticky) & ~sticky & SSR_READ_CLR_MASK) == '0);
	endproperty
	a_keep: assert property (p_keep)
		else $error("fault flag lost on bad frame");

	property p_echo;
		in_frame && sclk_rise && !cs_fall |=>
			sr[0] == $past(si_q[1]) && sr[SSR_W-1] == $past(sr[SSR_W-2]);
	endproperty
	a_echo: assert property (p_echo)
		else $error("input bit not echoed");

	property p_sel;
		!is_encfg |=> $stable(status_selector);
	endproperty
	a_sel: assert property (p_sel)
		else $error("selector changed without command");

	property p_dev;
		cs_fall && !status_selector[3] |=> sr == $past(dev_word) && dev_frame;
	endproperty
	a_dev: assert property (p_dev)
		else $error("device word not chosen");

	property p_high;
		supply_high_event |=> gauge1_drive_off && gauge0_drive_off
			&& sticky[SSR_B_HIGH] && sticky[SSR_B_FAULT];
	endproperty
	a_high: assert property (p_high)
		else $error("overvoltage not flagged or drivers on");

	property p_heat;
		gauge0_heat_event |=> sticky[SSR_B_HEAT0] && gauge0_drive_off;
	endproperty
	a_heat: assert property (p_heat)
		else $error("heat trip not latched");

	property p_race;
		clr_ok && supply_low_event |=> sticky[SSR_B_LOW];
	endproperty
	a_race: assert property (p_race)
		else $error("event lost during clear");

endmodule

// ### ssr_master.sv
`timescale 1ns/1ns
module ssr_master
(
	output logic      sclk,
	output logic      cs_n,
	output logic      si,
	input  wire logic so,
	input  wire logic so_oe
);
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si   = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// one frame, msb first, mode 0; rx keeps so as seen at each sclk rise
	task automatic xfer
	(
		input  int          n,
		input  logic [31:0] tx,
		output logic [31:0] rx
	);
		rx = '0;
		#7 cs_n = 1'b0;
		#170;
		for (int i = n - 1; i >= 0; i--)
		begin
			si = tx[i];
			#80 sclk = 1'b1;
			rx = {rx[30:0], so_oe ? so : 1'bx};
			#80 sclk = 1'b0;
		end
		#40 cs_n = 1'b1;
		// released line: show the inverse, never a stale value
		si = ~si;
		#200;
	endtask
endmodule

// ### ssr_top_bench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
	$display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module ssr_top_bench;
	import ssr_pkg::*;
	logic        clk, rst_n, sclk, cs_n, si, so, so_oe, cmd_valid;
	logic [8:0]  lv;
	logic [7:0]  ev;
	logic [15:0] acc_w, g0_w, g1_w, vel_w, cmd_word, st;
	logic [31:0] rx;
	logic [3:0]  sel, prev;
	wire  [1:0]  off, ren;
	int          failures = 0, total_checks = 0;
	int          nval = 0, exp_val = 0, nre = 0;

	ssr_top i_ssr_top
	(
		.clk(clk), .rst_n(rst_n), .spi_sclk(sclk), .spi_cs_n(cs_n),
		.spi_si(si), .spi_so(so), .spi_so_oe(so_oe),
		.gauge1_heading(lv[8]), .gauge0_heading(lv[7]),
		.gauge1_home_side(lv[6]), .gauge0_home_side(lv[5]),
		.gauge1_pending(lv[4]), .gauge0_pending(lv[3]),
		.clock_cal_bad(lv[2]), .gauge1_homing_active(lv[1]),
		.gauge0_homing_active(lv[0]),
		.supply_high_event(ev[0]), .supply_low_event(ev[1]),
		.gauge1_moved(ev[2]), .gauge0_moved(ev[3]),
		.gauge1_homing_cancel(ev[4]), .gauge0_homing_cancel(ev[5]),
		.gauge1_heat_event(ev[6]), .gauge0_heat_event(ev[7]),
		.homing_acc_word(acc_w), .gauge0_pos_word(g0_w),
		.gauge1_pos_word(g1_w), .velocity_word(vel_w),
		.cmd_word(cmd_word), .cmd_valid(cmd_valid), .status_selector(sel),
		.gauge1_drive_off(off[1]), .gauge0_drive_off(off[0]),
		.gauge1_reenable(ren[1]), .gauge0_reenable(ren[0])
	);

	ssr_master i_ssr_master
	(
		.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe)
	);

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk)
	begin
		if (cmd_valid === 1'b1)
			nval++;
		if (ren[1] === 1'b1)
			nre++;
		if (ren[0] === 1'b1)
			nre++;
	end

	////////////////////////////////////////////////////////////////////////
	// expected words
	function automatic logic [15:0] pick(input logic [3:0] s);
		if (!s[3])
			return {lv[8:3], 2'b00, lv[2], 7'h00} | st;
		if (!s[2])
			return acc_w;
		if (!s[1])
			return s[0] ? g1_w : g0_w;
		return vel_w;
	endfunction

	function automatic logic [31:0] cmdw(input logic [3:0] s,
		input logic [1:0] e);
		return {16'h0000, SSR_ENCFG_ADDR, 1'b0, s, 6'h00, e};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// access tasks
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic pulse(input int b);
		step(1);
		ev[b] = 1'b1;
		step(1);
		ev[b] = 1'b0;
	endtask

	task automatic frame(input int n, input logic [31:0] tx);
		i_ssr_master.xfer(n, tx, rx);
		if (n > 0 && n % 16 == 0)
			exp_val++;
		`CHK(so_oe, 1'b0)
		`CHK(nval, exp_val)
		step(1);
	endtask

	task automatic conclude();
		if (failures == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		#400_000;
		failures++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////////
	// tests
	initial
	begin
		rst_n = 1'b0;
		lv = 9'h16c;
		ev = 8'h00;
		st = 16'h0000;
		acc_w = 16'h8a31;
		g0_w = 16'h4c02;
		g1_w = 16'h2f17;
		vel_w = 16'h5e96;
		step(2);
		rst_n = 1'b1;
		`CHK(sel, SSR_SEL_RESET)
		`CHK({so_oe, off}, 3'h0)
		step(1);
		frame(16, 32'h0000_e0ff);
		`CHK(rx[15:0], pick(4'h0))
		`CHK(cmd_word, 16'he0ff)
		frame(16, 32'h0000_e0ff);
		`CHK(rx[15:0], pick(4'h0))
		lv = 9'h090;
		frame(16, 32'h0000_0000);
		`CHK(rx[15:0], pick(4'h0))
		pulse(0);
		`CHK(off, 2'b11)
		pulse(1);
		pulse(2);
		pulse(3);
		st = 16'h0370;
		frame(8, 32'h0000_00ff);
		frame(24, 32'h00ff_ffff);
		frame(16, 32'h0000_0000);
		`CHK(rx[15:0], pick(4'h0))
		st = 16'h0000;
		frame(16, 32'h0000_0000);
		`CHK(rx[15:0], pick(4'h0))
		`CHK(off, 2'b11)
		pulse(1);
		// undervoltage event lands on the clearing edge of a valid frame
		fork
			frame(16, 32'h0000_0000);
			begin
				@(posedge cs_n);
				step(2);
				ev[1] = 1'b1;
				step(1);
				ev[1] = 1'b0;
			end
		join
		st = 16'h0140;
		frame(16, cmdw(4'h0, 2'b11));
		`CHK(rx[15:0], pick(4'h0))
		st = 16'h0000;
		`CHK({off, nre}, {2'b00, 32'd2})
		pulse(6);
		st = 16'h0002;
		`CHK(off, 2'b10)
		pulse(7);
		st = 16'h0003;
		`CHK(off, 2'b11)
		frame(16, 32'h0000_0000);
		frame(16, cmdw(4'h0, 2'b10));
		`CHK(rx[15:0], pick(4'h0))
		st = 16'h0001;
		`CHK({off, nre}, {2'b01, 32'd3})
		frame(16, cmdw(4'h0, 2'b01));
		`CHK(rx[15:0], pick(4'h0))
		st = 16'h0000;
		`CHK({off, nre}, {2'b00, 32'd4})
		lv[1] = 1'b1;
		step(2);
		st = 16'h0008;
		frame(16, 32'h0000_0000);
		lv[1] = 1'b0;
		frame(16, 32'h0000_0000);
		`CHK(rx[15:0], pick(4'h0))
		st = 16'h0000;
		frame(16, 32'h0000_0000);
		`CHK(rx[15:0], pick(4'h0))
		lv[1:0] = 2'b11;
		step(2);
		lv[1:0] = 2'b00;
		pulse(4);
		pulse(5);
		frame(32, 32'h3c5a_e0f1);
		`CHK(rx[31:16], pick(4'h0))
		`CHK(rx[15:0], 16'h3c5a)
		`CHK(cmd_word, 16'he0f1)
		prev = 4'h0;
		for (int s = 0; s < 16; s++)
		begin
			frame(16, cmdw(s[3:0], 2'b00));
			`CHK(rx[15:0], pick(prev))
			`CHK(sel, s[3:0])
			prev = s[3:0];
		end
		frame(16, 32'h0000_e0ff);
		`CHK(sel, 4'hf)
		rst_n = 1'b0;
		step(2);
		rst_n = 1'b1;
		`CHK(sel, SSR_SEL_RESET)
		step(1);
		frame(16, 32'h0000_e0ff);
		`CHK(rx[15:0], pick(4'h0))
		conclude();
	end
endmodule
